// file: include/bucio_map.vh
`ifndef BUCIO_MAP_VH
`define BUCIO_MAP_VH
// ------------------------------------------------------------
// Register offsets (byte addresses)
// ------------------------------------------------------------
`define BUCIO_CTRL_OFS 8'h00
`define BUCIO_TEMP_MAX_OFS 8'h04
`define BUCIO_LOAD_MAX_OFS 8'h08
`define BUCIO_ENERGY_MAX_OFS 8'h0c
`define BUCIO_COOL_MS_OFS 8'h10
`define BUCIO_STATUS_OFS 8'h14
// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define BUCIO_CTRL_RST 2'h3
`define BUCIO_TEMP_MAX_RST 16'hffff
`define BUCIO_LOAD_MAX_RST 16'hffff
`define BUCIO_ENERGY_MAX_RST 16'hffff
`define BUCIO_COOL_MS_RST 16'h03e8
// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define BUCIO_CTRL_CHOP_BIT 0
`define BUCIO_CTRL_QD_BIT 1
`define BUCIO_FLT_ENABLE 0
`define BUCIO_FLT_TEMP 1
`define BUCIO_FLT_OVERCUR 2
`define BUCIO_FLT_LOAD 3
`define BUCIO_FLT_GROUND 4
`define BUCIO_ST_PREW_LSB 5
`define BUCIO_ST_COOLED_BIT 9
`define BUCIO_ST_INH_BIT 10
`define BUCIO_ST_QD_BIT 11
`define BUCIO_ST_RON_BIT 12
// ------------------------------------------------------------
// Prewarning fraction: level * DEN >= max * NUM
// ------------------------------------------------------------
`define BUCIO_PREW_NUM 3'h4
`define BUCIO_PREW_DEN 3'h5
// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define BUCIO_CLK_PERIOD_NS 10
`define BUCIO_MS_NS 1000000
`define BUCIO_MS_CYCLES (`BUCIO_MS_NS / `BUCIO_CLK_PERIOD_NS)
// ------------------------------------------------------------
// AXI responses
// ------------------------------------------------------------
`define BUCIO_RESP_OKAY 2'h0
`define BUCIO_RESP_DECERR 2'h3
`endif

// file: src/bucio_sync.v
`timescale 1ns/100ps
`default_nettype none
module bucio_sync #(
   parameter WIDTH = 2,
   parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
   input wire aclk,
   input wire aresetn,
   input wire [WIDTH-1:0] async_in,
   output wire [WIDTH-1:0] sync_out
);
   reg [WIDTH-1:0] meta_q;
   reg [WIDTH-1:0] sync_q;

   // First stage feeds only the second stage
   always @(posedge aclk) begin
      if (!aresetn) begin
         meta_q <= RST_VAL;
         sync_q <= RST_VAL;
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

   assign sync_out = sync_q;
endmodule // bucio_sync
`default_nettype wire

// file: src/bucio_top.v
// The placing of the registers and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "bucio_map.vh"
// Overview of operation
// - The unit is inhibited while the inhibit/acknowledge input is high and enabled while low.
// - A falling edge on the inhibit/acknowledge input clears all acknowledgeable faults.
// - A high quick-discharge input switches the braking resistor on by manual command.
// - With inhibit and quick discharge both high, inhibit wins and nothing switches on.
// - The prewarning output is high with no prewarning and low while one is active.
// - Prewarning is raised when unit temperature reaches 80 % of its maximum.
// - Prewarning is raised when the resistor load factor reaches 80 % of its maximum.
// - Prewarning is raised when braking energy reaches 80 % of its maximum.
// - Prewarning is raised when the connected resistor is not an approved type.
// - The fault output is high when ready and fault-free and falls when a fault occurs.
// - An overtemperature fault ignores acknowledge until a cooling phase has completed.
// - Missing enable, overtemperature, overcurrent, load factor and ground fault are faults.
module bucio_top #(
   parameter LVL_W = 16,
   parameter MS_CYCLES = `BUCIO_MS_CYCLES
) (
   input wire aclk,
   input wire aresetn,
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output wire [1:0] s_axi_bresp,
   output wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output wire [31:0] s_axi_rdata,
   output wire [1:0] s_axi_rresp,
   output wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire inhibit_ack_input,
   input wire quick_discharge_input,
   input wire brake_request,
   input wire [LVL_W-1:0] temp_level,
   input wire [LVL_W-1:0] load_level,
   input wire [LVL_W-1:0] energy_level,
   input wire resistor_approved,
   input wire overcurrent_trip,
   input wire ground_fault,
   output wire resistor_on,
   output wire prewarning_output,
   output wire fault_output
);
   localparam DIV_W = (MS_CYCLES > 1) ? $clog2(MS_CYCLES) : 1;
   localparam CMP_W = LVL_W + 3;
   localparam integer DIV_LAST_I = MS_CYCLES - 1;
   localparam [DIV_W-1:0] DIV_LAST = DIV_LAST_I[DIV_W-1:0];
   // ------------------------------------------------------------
   // Input synchronisation
   // ------------------------------------------------------------
   wire inh_s;
   wire qd_s;
   reg inh_prev_q;
   wire ack_edge;

   // Inhibit comes up asserted so the unit never brakes before the pin is seen
   bucio_sync #(
      .WIDTH(2),
      .RST_VAL(2'h1)
   ) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .async_in({quick_discharge_input, inhibit_ack_input}),
      .sync_out({qd_s, inh_s})
   );

   always @(posedge aclk) begin
      if (!aresetn) begin
         inh_prev_q <= 1'b1;
      end else begin
         inh_prev_q <= inh_s;
      end
   end

   assign ack_edge = inh_prev_q & ~inh_s;

   // ------------------------------------------------------------
   // Register file
   // ------------------------------------------------------------
   reg [1:0] ctrl_q;
   reg [15:0] temp_max_q;
   reg [15:0] load_max_q;
   reg [15:0] energy_max_q;
   reg [15:0] cool_ms_q;
   reg aw_hold_q;
   reg w_hold_q;
   reg [7:0] awaddr_q;
   reg [31:0] wdata_q;
   reg [3:0] wstrb_q;
   reg bvalid_q;
   reg [1:0] bresp_q;
   reg rvalid_q;
   reg [31:0] rdata_q;
   reg [1:0] rresp_q;
   wire aw_take;
   wire w_take;
   wire have_aw;
   wire have_w;
   wire do_write;
   wire [7:0] wr_addr;
   wire [31:0] wr_data;
   wire [3:0] wr_strb;
   wire wr_hit;
   wire ar_take;
   reg [31:0] rd_mux;
   reg rd_hit;
   wire [31:0] status_word;

   function [15:0] bucio_merge16;
      input [15:0] old_val;
      input [31:0] data;
      input [3:0] strb;
      begin
         bucio_merge16[7:0] = strb[0] ? data[7:0] : old_val[7:0];
         bucio_merge16[15:8] = strb[1] ? data[15:8] : old_val[15:8];
      end
   endfunction

   assign s_axi_awready = ~aw_hold_q & ~bvalid_q;
   assign s_axi_wready = ~w_hold_q & ~bvalid_q;
   assign aw_take = s_axi_awvalid & s_axi_awready;
   assign w_take = s_axi_wvalid & s_axi_wready;
   assign have_aw = aw_hold_q | aw_take;
   assign have_w = w_hold_q | w_take;
   assign do_write = have_aw & have_w & ~bvalid_q;
   assign wr_addr = aw_hold_q ? awaddr_q : s_axi_awaddr;
   assign wr_data = w_hold_q ? wdata_q : s_axi_wdata;
   assign wr_strb = w_hold_q ? wstrb_q : s_axi_wstrb;
   assign wr_hit = (wr_addr == `BUCIO_CTRL_OFS) || (wr_addr == `BUCIO_TEMP_MAX_OFS) ||
                   (wr_addr == `BUCIO_LOAD_MAX_OFS) || (wr_addr == `BUCIO_ENERGY_MAX_OFS) ||
                   (wr_addr == `BUCIO_COOL_MS_OFS) || (wr_addr == `BUCIO_STATUS_OFS);

   // Address and data may arrive in either order; the early one is parked
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_q <= 1'b0;
         w_hold_q <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h00000000;
         wstrb_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= `BUCIO_RESP_OKAY;
      end else begin
         if (do_write) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= wr_hit ? `BUCIO_RESP_OKAY : `BUCIO_RESP_DECERR;
         end else begin
            if (aw_take) begin
               aw_hold_q <= 1'b1;
               awaddr_q <= s_axi_awaddr;
            end
            if (w_take) begin
               w_hold_q <= 1'b1;
               wdata_q <= s_axi_wdata;
               wstrb_q <= s_axi_wstrb;
            end
            if (bvalid_q && s_axi_bready) begin
               bvalid_q <= 1'b0;
            end
         end
      end
   end

   // Status is read-only; a write to it is answered OKAY and dropped
   always @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q <= `BUCIO_CTRL_RST;
         temp_max_q <= `BUCIO_TEMP_MAX_RST;
         load_max_q <= `BUCIO_LOAD_MAX_RST;
         energy_max_q <= `BUCIO_ENERGY_MAX_RST;
         cool_ms_q <= `BUCIO_COOL_MS_RST;
      end else if (do_write) begin
         case (wr_addr)
            `BUCIO_CTRL_OFS: begin
               if (wr_strb[0]) begin
                  ctrl_q <= wr_data[1:0];
               end
            end
            `BUCIO_TEMP_MAX_OFS: temp_max_q <= bucio_merge16(temp_max_q, wr_data, wr_strb);
            `BUCIO_LOAD_MAX_OFS: load_max_q <= bucio_merge16(load_max_q, wr_data, wr_strb);
            `BUCIO_ENERGY_MAX_OFS: energy_max_q <= bucio_merge16(energy_max_q, wr_data, wr_strb);
            `BUCIO_COOL_MS_OFS: cool_ms_q <= bucio_merge16(cool_ms_q, wr_data, wr_strb);
            default: begin
            end
         endcase
      end
   end

   assign ar_take = s_axi_arvalid & ~rvalid_q;
   assign s_axi_arready = ~rvalid_q;

   always @* begin
      rd_mux = 32'h00000000;
      rd_hit = 1'b1;
      case (s_axi_araddr)
         `BUCIO_CTRL_OFS: rd_mux = {30'h00000000, ctrl_q};
         `BUCIO_TEMP_MAX_OFS: rd_mux = {16'h0000, temp_max_q};
         `BUCIO_LOAD_MAX_OFS: rd_mux = {16'h0000, load_max_q};
         `BUCIO_ENERGY_MAX_OFS: rd_mux = {16'h0000, energy_max_q};
         `BUCIO_COOL_MS_OFS: rd_mux = {16'h0000, cool_ms_q};
         `BUCIO_STATUS_OFS: rd_mux = status_word;
         default: rd_hit = 1'b0;
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h00000000;
         rresp_q <= `BUCIO_RESP_OKAY;
      end else if (ar_take) begin
         rvalid_q <= 1'b1;
         rdata_q <= rd_mux;
         rresp_q <= rd_hit ? `BUCIO_RESP_OKAY : `BUCIO_RESP_DECERR;
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;

   // ------------------------------------------------------------
   // Prewarning thresholds
   // ------------------------------------------------------------
   wire [3:0] prew_cause;
   wire [CMP_W-1:0] temp_scaled;
   wire [CMP_W-1:0] load_scaled;
   wire [CMP_W-1:0] energy_scaled;
   wire [CMP_W-1:0] temp_lim;
   wire [CMP_W-1:0] load_lim;
   wire [CMP_W-1:0] energy_lim;
   reg prew_n_q;

   // Scaling both sides avoids a divider for the fraction
   assign temp_scaled = temp_level * `BUCIO_PREW_DEN;
   assign load_scaled = load_level * `BUCIO_PREW_DEN;
   assign energy_scaled = energy_level * `BUCIO_PREW_DEN;
   assign temp_lim = temp_max_q[LVL_W-1:0] * `BUCIO_PREW_NUM;
   assign load_lim = load_max_q[LVL_W-1:0] * `BUCIO_PREW_NUM;
   assign energy_lim = energy_max_q[LVL_W-1:0] * `BUCIO_PREW_NUM;
   assign prew_cause[0] = temp_scaled >= temp_lim;
   assign prew_cause[1] = load_scaled >= load_lim;
   assign prew_cause[2] = energy_scaled >= energy_lim;
   assign prew_cause[3] = ~resistor_approved;

   always @(posedge aclk) begin
      if (!aresetn) begin
         prew_n_q <= 1'b1;
      end else begin
         prew_n_q <= ~|prew_cause;
      end
   end

   assign prewarning_output = prew_n_q;

   // ------------------------------------------------------------
   // Fault latches and cooling phase
   // ------------------------------------------------------------
   reg [4:0] fault_q;
   reg [4:0] fault_set;
   reg [4:0] fault_clr;
   wire overtemp;
   reg [DIV_W-1:0] div_q;
   wire ms_tick;
   reg [15:0] cool_cnt_q;
   reg cooled_q;
   reg fault_n_q;

   assign overtemp = temp_level >= temp_max_q[LVL_W-1:0];

   always @* begin
      fault_set = 5'h00;
      fault_set[`BUCIO_FLT_ENABLE] = inh_s;
      fault_set[`BUCIO_FLT_TEMP] = overtemp;
      fault_set[`BUCIO_FLT_OVERCUR] = overcurrent_trip;
      fault_set[`BUCIO_FLT_LOAD] = load_level >= load_max_q[LVL_W-1:0];
      fault_set[`BUCIO_FLT_GROUND] = ground_fault;
      fault_clr = ack_edge ? 5'h1f : 5'h00;
      fault_clr[`BUCIO_FLT_TEMP] = ack_edge & cooled_q;
   end

   // A source still present at the acknowledge edge keeps its fault
   always @(posedge aclk) begin
      if (!aresetn) begin
         fault_q <= 5'h00;
      end else begin
         fault_q <= fault_set | (fault_q & ~fault_clr);
      end
   end

   assign ms_tick = (div_q == DIV_LAST);

   always @(posedge aclk) begin
      if (!aresetn) begin
         div_q <= {DIV_W{1'b0}};
      end else if (ms_tick) begin
         div_q <= {DIV_W{1'b0}};
      end else begin
         div_q <= div_q + 1'b1;
      end
   end

   // Cooling restarts whenever the temperature climbs back to the limit
   always @(posedge aclk) begin
      if (!aresetn) begin
         cool_cnt_q <= 16'h0000;
         cooled_q <= 1'b0;
      end else if (!fault_q[`BUCIO_FLT_TEMP] || overtemp) begin
         cool_cnt_q <= 16'h0000;
         cooled_q <= 1'b0;
      end else if (cool_cnt_q >= cool_ms_q) begin
         cooled_q <= 1'b1;
      end else if (ms_tick) begin
         cool_cnt_q <= cool_cnt_q + 16'h0001;
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         fault_n_q <= 1'b1;
      end else begin
         fault_n_q <= ~|fault_q;
      end
   end

   assign fault_output = fault_n_q;

   // ------------------------------------------------------------
   // Resistor switch
   // ------------------------------------------------------------
   reg ron_q;
   wire auto_brake;
   wire manual_brake;

   assign auto_brake = ctrl_q[`BUCIO_CTRL_CHOP_BIT] & brake_request;
   assign manual_brake = ctrl_q[`BUCIO_CTRL_QD_BIT] & qd_s;

   // Inhibit is checked first so it overrides a manual request
   always @(posedge aclk) begin
      if (!aresetn) begin
         ron_q <= 1'b0;
      end else if (inh_s) begin
         ron_q <= 1'b0;
      end else begin
         ron_q <= ~|fault_q & (auto_brake | manual_brake);
      end
   end

   assign resistor_on = ron_q;

   // ------------------------------------------------------------
   // Status word
   // ------------------------------------------------------------
   assign status_word = {19'h00000, ron_q, qd_s, inh_s, cooled_q, prew_cause, fault_q};
endmodule // bucio_top
`default_nettype wire

// file: verification/bucio_checker.sv
`timescale 1ns/100ps
`default_nettype none
module bucio_checker #(
   parameter LVL_W = 16
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic inhibit_ack_input,
   input wire logic quick_discharge_input,
   input wire logic brake_request,
   input wire logic [LVL_W-1:0] temp_level,
   input wire logic [LVL_W-1:0] load_level,
   input wire logic [LVL_W-1:0] energy_level,
   input wire logic resistor_approved,
   input wire logic overcurrent_trip,
   input wire logic ground_fault,
   input wire logic resistor_on,
   input wire logic prewarning_output,
   input wire logic fault_output
);
   // ----------
   // Properties
   // ----------
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Pins cross two sync flops, so pin rules look back over several cycles
   a_inhibit_wins: assert property (inhibit_ack_input [*4] |=> !resistor_on)
      else $error("resistor on while inhibited");
   a_qd_turns_on: assert property (
      (quick_discharge_input && !inhibit_ack_input && fault_output) [*5] |-> resistor_on)
      else $error("quick discharge ignored");
   a_qd_idle_off: assert property (
      (!quick_discharge_input && !brake_request) [*5] |-> !resistor_on)
      else $error("resistor on without request");
   a_overcur_fault: assert property (overcurrent_trip |-> ##2 !fault_output)
      else $error("overcurrent not reported");
   a_ground_fault: assert property (ground_fault |-> ##2 !fault_output)
      else $error("ground fault not reported");
   a_enable_fault: assert property (inhibit_ack_input [*5] |-> !fault_output)
      else $error("missing enable not reported");
   a_resistor_prew: assert property (!resistor_approved |=> !prewarning_output)
      else $error("unknown resistor without prewarning");
   a_prew_clear: assert property (
      (resistor_approved && temp_level == 0 && load_level == 0 && energy_level == 0)
      |=> prewarning_output)
      else $error("prewarning without cause");
   a_clear_by_ack: assert property (
      $rose(fault_output) |-> !$past(inhibit_ack_input) && !$past(inhibit_ack_input, 2))
      else $error("fault cleared without acknowledge");
   c_resistor_on: cover property ($rose(resistor_on));
   c_fault_clear: cover property ($rose(fault_output));
   c_prewarn: cover property ($fell(prewarning_output));
endmodule // bucio_checker
bind bucio_top bucio_checker #(.LVL_W(LVL_W)) u_chk (
   .aclk(aclk), .aresetn(aresetn),
   .inhibit_ack_input(inhibit_ack_input), .quick_discharge_input(quick_discharge_input),
   .brake_request(brake_request), .temp_level(temp_level), .load_level(load_level),
   .energy_level(energy_level), .resistor_approved(resistor_approved),
   .overcurrent_trip(overcurrent_trip), .ground_fault(ground_fault),
   .resistor_on(resistor_on), .prewarning_output(prewarning_output),
   .fault_output(fault_output)
);
`default_nettype wire

// file: verification/bucio_plc_model.sv
`timescale 1ns/100ps
`default_nettype none
module bucio_plc_model (
   input wire logic aclk,
   input wire logic want_inhibit,
   input wire logic want_qd,
   input wire logic [1:0] lag,
   output logic inhibit_ack_input,
   output logic quick_discharge_input,
   output logic [3:0] qd_requests
);
   // -----------------------
   // Controller output stage
   // -----------------------
   logic [3:0] inh_q = 4'hf;
   logic [3:0] qd_q = 4'h0;
   initial begin
      inhibit_ack_input = 1'b1;
      quick_discharge_input = 1'b0;
      qd_requests = 4'h0;
   end
   // Lag models a slow scan; the pin delay keeps edges away from the unit's clock
   always @(posedge aclk) begin
      inh_q <= {inh_q[2:0], want_inhibit};
      qd_q <= {qd_q[2:0], want_qd};
      inhibit_ack_input <= #2 inh_q[lag];
      if (qd_q[lag] && !quick_discharge_input && qd_requests < 4'h2) begin
         quick_discharge_input <= #2 1'b1;
         qd_requests <= qd_requests + 4'h1;
      end else if (!qd_q[lag]) begin
         quick_discharge_input <= #2 1'b0;
      end
   end
endmodule // bucio_plc_model
`default_nettype wire

// file: verification/tb_braking_unit_control_io.sv
`timescale 1ns/100ps
`default_nettype none
module tb_braking_unit_control_io;
   logic aclk;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic want_inhibit = 1'b1, want_qd = 1'b0, brake_request = 1'b0, resistor_approved = 1'b1;
   logic overcurrent_trip = 1'b0, ground_fault = 1'b0;
   logic [1:0] lag = 2'h0;
   logic [15:0] lvl [3] = '{16'h0, 16'h0, 16'h0};
   wire awready, wready, bvalid, arready, rvalid, inh_pin, qd_pin;
   wire resistor_on, prewarning_output, fault_output;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire [3:0] qd_requests;
   wire [2:0] outs = {resistor_on, prewarning_output, fault_output};
   int n_errors = 0;
   int compares = 0;
   bucio_top #(.MS_CYCLES(4)) uut (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .inhibit_ack_input(inh_pin), .quick_discharge_input(qd_pin),
      .brake_request(brake_request), .temp_level(lvl[0]), .load_level(lvl[1]),
      .energy_level(lvl[2]), .resistor_approved(resistor_approved),
      .overcurrent_trip(overcurrent_trip), .ground_fault(ground_fault),
      .resistor_on(resistor_on), .prewarning_output(prewarning_output),
      .fault_output(fault_output)
   );
   bucio_plc_model u_plc (
      .aclk(aclk), .want_inhibit(want_inhibit), .want_qd(want_qd), .lag(lag),
      .inhibit_ack_input(inh_pin), .quick_discharge_input(qd_pin), .qd_requests(qd_requests)
   );
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   // ----------------
   // Helpers
   // ----------------
   task automatic close_out;
      $display("compares %0d errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Handshakes are judged at the falling edge, where they equal the next rising edge
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      logic aw_t, w_t, b_t;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      n = 0;
      b_t = 1'b0;
      while (!b_t && n < 50) begin
         @(negedge aclk);
         aw_t = awvalid && awready;
         w_t = wvalid && wready;
         b_t = bvalid;
         if (b_t) check(bresp, er);
         @(posedge aclk);
         if (aw_t) awvalid <= 1'b0;
         if (w_t) wvalid <= 1'b0;
         n++;
      end
      bready <= 1'b0;
      if (!b_t) begin
         n_errors++;
         close_out;
      end
   endtask
   task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      int n;
      logic ar_t, r_t;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      n = 0;
      r_t = 1'b0;
      while (!r_t && n < 50) begin
         @(negedge aclk);
         ar_t = arvalid && arready;
         r_t = rvalid;
         if (r_t) check(rdata, ed);
         if (r_t) check(rresp, er);
         @(posedge aclk);
         if (ar_t) arvalid <= 1'b0;
         n++;
      end
      rready <= 1'b0;
      if (!r_t) begin
         n_errors++;
         close_out;
      end
   endtask
   task automatic wait_out(input int i, input logic v);
      int n;
      n = 0;
      @(negedge aclk);
      while (outs[i] !== v && n < 40) begin
         @(negedge aclk);
         n++;
      end
      check(outs[i], v);
      if (outs[i] !== v) close_out;
   endtask
   task automatic ack;
      @(posedge aclk);
      want_inhibit <= 1'b1;
      repeat (6) @(posedge aclk);
      want_inhibit <= 1'b0;
   endtask
   // ----------------
   // Main sequence
   // ----------------
   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      axi_rd(8'h00, 32'h3, 2'h0);
      axi_rd(8'h04, 32'hffff, 2'h0);
      axi_rd(8'h10, 32'h3e8, 2'h0);
      axi_rd(8'h18, 32'h0, 2'h3);
      axi_wr(8'h18, 32'h1, 2'h3);
      axi_wr(8'h14, 32'h0, 2'h0);
      // Cooling long enough that an early acknowledge surely lands inside it
      axi_wr(8'h10, 32'ha, 2'h0);
      for (int i = 1; i < 4; i++) axi_wr(8'(4 * i), 32'h64, 2'h0);
      axi_rd(8'h08, 32'h64, 2'h0);
      wait_out(0, 1'b0);
      @(posedge aclk);
      want_inhibit <= 1'b0;
      wait_out(0, 1'b1);
      axi_wr(8'h00, 32'h2, 2'h0);
      @(posedge aclk);
      brake_request <= 1'b1;
      repeat (4) @(negedge aclk);
      check(outs[2], 1'b0);
      axi_wr(8'h00, 32'h3, 2'h0);
      wait_out(2, 1'b1);
      @(posedge aclk);
      brake_request <= 1'b0;
      wait_out(2, 1'b0);
      @(posedge aclk);
      want_qd <= 1'b1;
      lag <= 2'h3;
      wait_out(2, 1'b1);
      @(posedge aclk);
      want_inhibit <= 1'b1;
      wait_out(2, 1'b0);
      repeat (6) @(negedge aclk);
      check(outs[2], 1'b0);
      @(posedge aclk);
      want_inhibit <= 1'b0;
      wait_out(2, 1'b1);
      @(posedge aclk);
      want_qd <= 1'b0;
      lag <= 2'h0;
      wait_out(2, 1'b0);
      check(qd_requests, 32'h1);
      @(posedge aclk);
      resistor_approved <= 1'b0;
      wait_out(1, 1'b0);
      @(posedge aclk);
      resistor_approved <= 1'b1;
      wait_out(1, 1'b1);
      for (int i = 0; i < 3; i++) begin
         @(posedge aclk);
         lvl[i] <= 16'h4f;
         repeat (3) @(negedge aclk);
         check(outs[1], 1'b1);
         @(posedge aclk);
         lvl[i] <= 16'h50;
         wait_out(1, 1'b0);
         @(posedge aclk);
         lvl[i] <= 16'd0;
         wait_out(1, 1'b1);
      end
      for (int i = 0; i < 3; i++) begin
         @(posedge aclk);
         case (i)
            0: overcurrent_trip <= 1'b1;
            1: ground_fault <= 1'b1;
            default: lvl[1] <= 16'h64;
         endcase
         @(posedge aclk);
         overcurrent_trip <= 1'b0;
         ground_fault <= 1'b0;
         lvl[1] <= 16'd0;
         wait_out(0, 1'b0);
         ack;
         wait_out(0, 1'b1);
      end
      @(posedge aclk);
      lvl[0] <= 16'h64;
      wait_out(0, 1'b0);
      @(posedge aclk);
      lvl[0] <= 16'd0;
      ack;
      repeat (8) @(negedge aclk);
      check(outs[0], 1'b0);
      axi_rd(8'h14, 32'h2, 2'h0);
      repeat (60) @(posedge aclk);
      axi_rd(8'h14, 32'h202, 2'h0);
      ack;
      wait_out(0, 1'b1);
      close_out;
   end
   initial begin
      repeat (100000) @(posedge aclk);
      n_errors++;
      close_out;
   end
endmodule // tb_braking_unit_control_io
`default_nettype wire
